// file: core/ccpu_consts.svh
`ifndef CCPU_CONSTS_SVH
`define CCPU_CONSTS_SVH

// word offsets on the avalon bus (byte address = 4 * index)
`define CCPU_IDX_CC1_LOW      4'h0
`define CCPU_IDX_CC1_HIGH     4'h1
`define CCPU_IDX_CTL1         4'h2
`define CCPU_IDX_CC2_LOW      4'h3
`define CCPU_IDX_CC2_HIGH     4'h4
`define CCPU_IDX_CTL2         4'h5
`define CCPU_IDX_T1_LOW       4'h6
`define CCPU_IDX_T1_HIGH      4'h7
`define CCPU_IDX_T2           4'h8
`define CCPU_IDX_PERIOD       4'h9
`define CCPU_IDX_STATUS       4'ha
`define CCPU_IDX_ENABLE       4'hb
`define CCPU_IDX_TIMER_CTL    4'hc
`define CCPU_IDX_PORT         4'hd
// printed register offsets kept for reference
`define CCPU_OFS_CC1_LOW      8'h15
`define CCPU_OFS_CC1_HIGH     8'h16
`define CCPU_OFS_CTL1         8'h17
`define CCPU_OFS_CTL2         8'h1d
// control field positions
`define CCPU_MODE_LSB         0
`define CCPU_MODE_MSB         3
`define CCPU_DUTY_LSB         4
`define CCPU_DUTY_MSB         5
`define CCPU_CTL_IMPL_MASK    8'h3f
// reset values
`define CCPU_CTL_RESET        8'h00
`define CCPU_PERIOD_RESET     8'hff
// capture prescale counts
`define CCPU_PRESCALE_4       4'h3
`define CCPU_PRESCALE_16      4'hf
// status bits
`define CCPU_ST_MATCH1        0
`define CCPU_ST_MATCH2        1
`define CCPU_ST_T1_OVF        2

`endif

// file: core/ccpu_pkg.sv
package ccpu_pkg;
    // mode_select_bits encodings
    typedef enum logic [3:0] {
        CCPU_OFF        = 4'h0,
        CCPU_CAP_FALL   = 4'h4,
        CCPU_CAP_RISE   = 4'h5,
        CCPU_CAP_RISE4  = 4'h6,
        CCPU_CAP_RISE16 = 4'h7,
        CCPU_CMP_HIGH   = 4'h8,
        CCPU_CMP_LOW    = 4'h9,
        CCPU_CMP_SOFT   = 4'ha,
        CCPU_CMP_TRIG   = 4'hb
    } ccpu_mode_t;

    typedef struct packed {
        logic [3:0] prescale_cnt;
        logic       pin_last;
        logic       out_latch;
        logic [1:0] duty_low_latch;
        logic [7:0] high_byte;
        logic [7:0] low_byte;
    } ccpu_unit_state_t;
endpackage : ccpu_pkg

// file: core/ccpu_unit.sv
`timescale 1ns/10ps
`include "ccpu_consts.svh"

module ccpu_unit (
    input  wire logic        core_clk,     // system clock
    input  wire logic        rst_n,        // async reset, active low
    input  wire logic [5:0]  ctl,          // control bits 5..0
    input  wire logic        ctl_wr,       // control written this cycle
    input  wire logic        low_wr,       // low byte write strobe
    input  wire logic        high_wr,      // high byte write strobe
    input  wire logic [7:0]  wdata,        // write data
    input  wire logic        pin_in,       // pin level seen by edge detector
    input  wire logic [15:0] t1_value,     // sixteen_bit_timebase
    input  wire logic [9:0]  t2_ext,       // eight_bit_timebase with two low bits
    input  wire logic        t2_reload,    // period end reload
    output logic [7:0]       low_byte,     // capture_compare_low_byte
    output logic [7:0]       high_byte,    // capture_compare_high_byte
    output logic             unit_out,     // compare or pwm output latch
    output logic             match_evt,    // one-cycle event pulse
    output logic             trig_evt      // special event trigger pulse
);
    ccpu_pkg::ccpu_unit_state_t s_reg;
    ccpu_pkg::ccpu_unit_state_t s_next;
    logic [3:0] mode;
    logic       is_cap;
    logic       is_cmp;
    logic       is_pwm;
    logic       rise;
    logic       fall;
    logic       cap_evt;
    logic       cmp_hit;
    logic       evt_next;
    logic       trig_next;
    logic       evt_reg;
    logic       trig_reg;

    assign mode   = ctl[`CCPU_MODE_MSB:`CCPU_MODE_LSB];
    assign is_cap = (mode[3:2] == 2'b01);
    assign is_cmp = (mode[3:2] == 2'b10);
    assign is_pwm = (mode[3:2] == 2'b11);
    assign rise   = pin_in & ~s_reg.pin_last;
    assign fall   = ~pin_in & s_reg.pin_last;
    assign cmp_hit = is_cmp && ({s_reg.high_byte, s_reg.low_byte} == t1_value);

    // capture event selection per prescale code
    always_comb begin
        cap_evt = 1'b0;
        unique case (mode)
            ccpu_pkg::CCPU_CAP_FALL:   cap_evt = fall;
            ccpu_pkg::CCPU_CAP_RISE:   cap_evt = rise;
            ccpu_pkg::CCPU_CAP_RISE4:  cap_evt = rise && (s_reg.prescale_cnt[1:0] == 2'(`CCPU_PRESCALE_4));
            ccpu_pkg::CCPU_CAP_RISE16: cap_evt = rise && s_reg.prescale_cnt == `CCPU_PRESCALE_16;
            default:                   cap_evt = 1'b0;
        endcase
    end

    // next state of the unit
    always_comb begin
        s_next          = s_reg;
        s_next.pin_last = pin_in;
        evt_next        = 1'b0;
        trig_next       = 1'b0;
        if (low_wr) begin
            s_next.low_byte = wdata;
        end
        if (high_wr && !is_pwm) begin                          // high byte read-only in pwm
            s_next.high_byte = wdata;
        end
        // prescaler kept only while capturing; direct prescale switch leaves it
        if (!is_cap) begin
            s_next.prescale_cnt = 4'h0;
        end else if (rise) begin
            s_next.prescale_cnt = s_reg.prescale_cnt + 4'h1;
        end
        if (cap_evt) begin
            {s_next.high_byte, s_next.low_byte} = t1_value;
            evt_next = 1'b1;
        end
        if (cmp_hit) begin
            evt_next = 1'b1;
            unique case (mode)
                ccpu_pkg::CCPU_CMP_HIGH: s_next.out_latch = 1'b1;
                ccpu_pkg::CCPU_CMP_LOW:  s_next.out_latch = 1'b0;
                ccpu_pkg::CCPU_CMP_TRIG: trig_next = 1'b1;
                default:                 s_next.out_latch = s_reg.out_latch;
            endcase
        end
        if (is_pwm) begin
            // double buffered duty, loaded at period end keeps pwm glitchless
            if (t2_reload) begin
                s_next.high_byte      = s_reg.low_byte;
                s_next.duty_low_latch = ctl[`CCPU_DUTY_MSB:`CCPU_DUTY_LSB];
                s_next.out_latch      = ({s_reg.low_byte, ctl[5:4]} != 10'h000);
            // latch is registered, so look one count ahead to drop exactly at the match
            end else if ({s_reg.high_byte, s_reg.duty_low_latch} == 10'(t2_ext + 10'h001)) begin
                s_next.out_latch = 1'b0;
            end
        end
        // off forces the whole unit idle and output latch low
        if (mode == ccpu_pkg::CCPU_OFF) begin
            s_next.out_latch      = 1'b0;
            s_next.duty_low_latch = 2'h0;
        end
    end

    // single state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg    <= '0;
            evt_reg  <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            s_reg    <= s_next;
            evt_reg  <= evt_next;
            trig_reg <= trig_next;
        end
    end

    assign low_byte  = s_reg.low_byte;
    assign high_byte = s_reg.high_byte;
    assign unit_out  = s_reg.out_latch;
    assign match_evt = evt_reg;
    assign trig_evt  = trig_reg;
endmodule : ccpu_unit

// file: core/ccpu_top.sv
`timescale 1ns/10ps
`include "ccpu_consts.svh"


module ccpu_top (
    input  wire logic        core_clk,       // 50 mhz system clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic [3:0]  address,        // avalon word address
    input  wire logic        read,           // avalon read
    input  wire logic        write,          // avalon write
    input  wire logic [31:0] writedata,      // avalon write data
    input  wire logic [3:0]  byteenable,     // avalon byte enables
    output logic [31:0]      readdata,       // avalon read data
    output logic             waitrequest,    // avalon wait
    input  wire logic        pin1_in,        // first event_pin level
    input  wire logic        pin2_in,        // second event_pin level
    input  wire logic        adc_enabled,    // converter is enabled
    output logic             pin1_out,       // first event_pin drive value
    output logic             pin1_oe,        // first event_pin drive enable
    output logic             pin2_out,       // second event_pin drive value
    output logic             pin2_oe,        // second event_pin drive enable
    output logic             adc_start       // conversion start pulse
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [15:0] t1;
        logic [7:0]  t2;
        logic [1:0]  t2_sub;
        logic [7:0]  period;
        logic [2:0]  status;
        logic [2:0]  enable;
        logic [1:0]  timer_ctl;
        logic [3:0]  port;
        logic        adc_go;
    } ccpu_top_state_t;

    ccpu_top_state_t s_reg;
    ccpu_top_state_t s_next;
    logic [7:0]  u1_low;
    logic [7:0]  u1_high;
    logic [7:0]  u2_low;
    logic [7:0]  u2_high;
    logic        u1_out;
    logic        u2_out;
    logic        u1_evt;
    logic        u2_evt;
    logic        u1_trig;
    logic        u2_trig;
    logic        acc;
    logic        wr_go;
    logic        lane0;
    logic        t2_reload;
    logic [9:0]  t2_ext;
    logic        pin1_seen;
    logic        pin2_seen;

    assign acc   = (read | write) & ~s_reg.ack;
    // write lands at the edge where waitrequest is low, as the master expects
    assign wr_go = write & s_reg.ack & lane0;
    assign lane0 = byteenable[0];
    // eight_bit_timebase at period and sub count done: reload next
    assign t2_reload = s_reg.timer_ctl[1] && (s_reg.t2 == s_reg.period) && (s_reg.t2_sub == 2'h3);
    assign t2_ext    = {s_reg.t2, s_reg.t2_sub};
    // pin level plus port latch when driving out reaches the detector
    assign pin1_seen = s_reg.port[1] ? s_reg.port[0] : pin1_in;
    assign pin2_seen = s_reg.port[3] ? s_reg.port[2] : pin2_in;

    function automatic logic hit(input logic [3:0] idx);
        hit = wr_go && (address == idx);
    endfunction : hit

    // both units share one eight_bit_timebase for pwm
    ccpu_unit u_first (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .ctl       (s_reg.ctl1[5:0]),
        .ctl_wr    (hit(`CCPU_IDX_CTL1)),
        .low_wr    (hit(`CCPU_IDX_CC1_LOW)),
        .high_wr   (hit(`CCPU_IDX_CC1_HIGH)),
        .wdata     (writedata[7:0]),
        .pin_in    (pin1_seen),
        .t1_value  (s_reg.t1),
        .t2_ext    (t2_ext),
        .t2_reload (t2_reload),
        .low_byte  (u1_low),
        .high_byte (u1_high),
        .unit_out  (u1_out),
        .match_evt (u1_evt),
        .trig_evt  (u1_trig)
    );

    ccpu_unit u_second (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .ctl       (s_reg.ctl2[5:0]),
        .ctl_wr    (hit(`CCPU_IDX_CTL2)),
        .low_wr    (hit(`CCPU_IDX_CC2_LOW)),
        .high_wr   (hit(`CCPU_IDX_CC2_HIGH)),
        .wdata     (writedata[7:0]),
        .pin_in    (pin2_seen),
        .t1_value  (s_reg.t1),
        .t2_ext    (t2_ext),
        .t2_reload (t2_reload),
        .low_byte  (u2_low),
        .high_byte (u2_high),
        .unit_out  (u2_out),
        .match_evt (u2_evt),
        .trig_evt  (u2_trig)
    );

    // registers, timebases and bus answer
    always_comb begin
        s_next        = s_reg;
        s_next.ack    = acc;
        s_next.adc_go = 1'b0;
        // timebase increments only when enabled; 2-bit sub count feeds pwm
        if (s_reg.timer_ctl[0]) begin
            if (s_reg.t1 == 16'hffff) begin
                s_next.status[`CCPU_ST_T1_OVF] = 1'b1;
            end
            s_next.t1 = s_reg.t1 + 16'h0001;
        end
        // trigger clear skips the overflow flag
        if (u1_trig || u2_trig) begin
            s_next.t1 = 16'h0000;
        end
        if (u2_trig && adc_enabled) begin
            s_next.adc_go = 1'b1;
        end
        if (s_reg.timer_ctl[1]) begin
            s_next.t2_sub = s_reg.t2_sub + 2'h1;
            if (t2_reload) begin
                s_next.t2 = 8'h00;
            end else if (s_reg.t2_sub == 2'h3) begin
                s_next.t2 = s_reg.t2 + 8'h01;
            end
        end
        // software clears status bits by writing ones
        if (hit(`CCPU_IDX_STATUS)) begin
            s_next.status = s_reg.status & ~writedata[2:0];
        end
        // match flags set after clear so a same-cycle match event is not lost
        if (u1_evt) begin
            s_next.status[`CCPU_ST_MATCH1] = 1'b1;
        end
        if (u2_evt) begin
            s_next.status[`CCPU_ST_MATCH2] = 1'b1;
        end
        if (hit(`CCPU_IDX_CTL1)) begin
            s_next.ctl1 = writedata[7:0] & `CCPU_CTL_IMPL_MASK;
        end
        if (hit(`CCPU_IDX_CTL2)) begin
            s_next.ctl2 = writedata[7:0] & `CCPU_CTL_IMPL_MASK;
        end
        // software write comes last so it wins over the trigger clear
        if (hit(`CCPU_IDX_T1_LOW)) begin
            s_next.t1[7:0] = writedata[7:0];
        end
        if (hit(`CCPU_IDX_T1_HIGH)) begin
            s_next.t1[15:8] = writedata[7:0];
        end
        if (hit(`CCPU_IDX_T2)) begin
            s_next.t2     = writedata[7:0];
            s_next.t2_sub = 2'h0;
        end
        if (hit(`CCPU_IDX_PERIOD)) begin
            s_next.period = writedata[7:0];
        end
        if (hit(`CCPU_IDX_ENABLE)) begin
            s_next.enable = writedata[2:0];
        end
        if (hit(`CCPU_IDX_TIMER_CTL)) begin
            s_next.timer_ctl = writedata[1:0];
        end
        if (hit(`CCPU_IDX_PORT)) begin
            s_next.port = writedata[3:0];
        end
        // read mux; unmapped words read zero
        s_next.rdata = 32'h0000_0000;
        if (read && acc) begin
            unique case (address)
                `CCPU_IDX_CC1_LOW:   s_next.rdata = {24'h0, u1_low};
                `CCPU_IDX_CC1_HIGH:  s_next.rdata = {24'h0, u1_high};
                `CCPU_IDX_CTL1:      s_next.rdata = {24'h0, s_reg.ctl1};
                `CCPU_IDX_CC2_LOW:   s_next.rdata = {24'h0, u2_low};
                `CCPU_IDX_CC2_HIGH:  s_next.rdata = {24'h0, u2_high};
                `CCPU_IDX_CTL2:      s_next.rdata = {24'h0, s_reg.ctl2};
                `CCPU_IDX_T1_LOW:    s_next.rdata = {24'h0, s_reg.t1[7:0]};
                `CCPU_IDX_T1_HIGH:   s_next.rdata = {24'h0, s_reg.t1[15:8]};
                `CCPU_IDX_T2:        s_next.rdata = {24'h0, s_reg.t2};
                `CCPU_IDX_PERIOD:    s_next.rdata = {24'h0, s_reg.period};
                `CCPU_IDX_STATUS:    s_next.rdata = {29'h0, s_reg.status};
                `CCPU_IDX_ENABLE:    s_next.rdata = {29'h0, s_reg.enable};
                `CCPU_IDX_TIMER_CTL: s_next.rdata = {30'h0, s_reg.timer_ctl};
                `CCPU_IDX_PORT:      s_next.rdata = {28'h0, s_reg.port};
                default:             s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.period <= `CCPU_PERIOD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin drive: unit latch in compare and pwm modes, port latch in off and capture modes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_out <= 1'b0;
            pin1_oe  <= 1'b0;
            pin2_out <= 1'b0;
            pin2_oe  <= 1'b0;
        end else begin
            pin1_out <= (s_next.ctl1[3:2] == 2'b00 || s_next.ctl1[3:2] == 2'b01)
                        ? s_next.port[0] : u1_out;
            pin1_oe  <= s_next.port[1];
            pin2_out <= (s_next.ctl2[3:2] == 2'b00 || s_next.ctl2[3:2] == 2'b01)
                        ? s_next.port[2] : u2_out;
            pin2_oe  <= s_next.port[3];
        end
    end

    assign readdata    = s_reg.rdata;
    assign waitrequest = ~s_reg.ack;
    assign adc_start   = s_reg.adc_go;
endmodule : ccpu_top

// file: sim/ccpu_pin_src.sv
`timescale 1ns/10ps

// far-side source on one event_pin
module ccpu_pin_src (
    input  wire logic core_clk, // system clock
    input  wire logic drv_oe,   // design drives the pin
    input  wire logic drv_val,  // design drive value
    output logic      wire_lvl  // resolved pin level
);
    logic src_lvl = 1'b0;

    // the source yields while the design drives, as software keeps one driver
    assign wire_lvl = drv_oe ? drv_val : src_lvl;

    // whole pulses, high held gap cycles, low gap cycles plus one before the next pulse, launched after an edge
    task automatic pulses(input int n, input int gap);
        repeat (n) begin
            @(posedge core_clk);
            src_lvl <= 1'b1;
            repeat (gap) @(posedge core_clk);
            src_lvl <= 1'b0;
            repeat (gap) @(posedge core_clk);
        end
    endtask : pulses
endmodule : ccpu_pin_src

// file: sim/ccpu_top_sva.sv
`timescale 1ns/10ps
`include "ccpu_consts.svh"

module ccpu_top_sva (
    input wire logic        core_clk,    // clock
    input wire logic        rst_n,       // reset
    input wire logic [3:0]  address,     // word index
    input wire logic        read,        // read strobe
    input wire logic        write,       // write strobe
    input wire logic [31:0] readdata,    // read data
    input wire logic        waitrequest, // wait
    input wire logic        adc_enabled, // converter on
    input wire logic        adc_start,   // conversion start
    input wire logic        pin1_oe,     // pin1 drive
    input wire logic        pin2_oe      // pin2 drive
);
    // one domain, clock and reset given once
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // bus answers: one cycle late, one cycle long, never unasked
    property p_ack_next;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_ack_once;
        !waitrequest |=> waitrequest;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("answer longer than one cycle");
    property p_no_spur;
        !waitrequest |-> $past(read || write);
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("answer without request");
    property p_upper_zero;
        !waitrequest && read |-> readdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_ctl_unimpl;
        !waitrequest && read && (address == `CCPU_IDX_CTL1 || address == `CCPU_IDX_CTL2)
            |-> readdata[7:6] == 2'b00;
    endproperty
    a_ctl_unimpl: assert property (p_ctl_unimpl) else $error("control top bits set");

    // conversion start only when the converter is on, as a single pulse
    property p_adc_gate;
        adc_start |-> $past(adc_enabled);
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("start while converter off");
    property p_adc_pulse;
        adc_start |=> !adc_start;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse too long");

    // reset itself must hold everything quiet
    property p_reset_idle;
        disable iff (1'b0) !rst_n |-> waitrequest && !adc_start && !pin1_oe && !pin2_oe
            && readdata == 32'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs busy in reset");
endmodule : ccpu_top_sva

bind ccpu_top ccpu_top_sva ccpu_top_sva_i (
    .core_clk, .rst_n, .address, .read, .write, .readdata, .waitrequest,
    .adc_enabled, .adc_start, .pin1_oe, .pin2_oe
);

// file: sim/ccpu_top_tb.sv
`timescale 1ns/10ps
`include "ccpu_consts.svh"

module ccpu_top_tb;
    logic core_clk, rst_n, read, write, adc_enabled, waitrequest, adc_start;
    logic pin1_in, pin2_in, pin1_out, pin1_oe, pin2_out, pin2_oe;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata;
    logic [7:0]  q;
    logic [15:0] tv, h1, h2, adc_base;
    logic [15:0] n_adc = 16'h0;
    int          fails = 0;
    int          n_compared = 0;
    logic [3:0]  cap_mode [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int          cap_cnt  [4] = '{1, 1, 4, 16};
    // compare rows: control index, mode, converter, flags, timebase high, pin, starts
    logic [3:0]  r_ctl [6] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h5, 4'h5};
    logic [3:0]  r_md  [6] = '{4'h9, 4'h8, 4'ha, 4'hb, 4'hb, 4'hb};
    logic        r_adc [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0]  r_st  [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03};
    logic [7:0]  r_t1h [6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    logic        r_pin [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [15:0] r_n   [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0};

    ccpu_top ccpu_top_i (
        .core_clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .pin1_in, .pin2_in, .adc_enabled,
        .pin1_out, .pin1_oe, .pin2_out, .pin2_oe, .adc_start
    );
    ccpu_pin_src pin1_src (.core_clk, .drv_oe(pin1_oe), .drv_val(pin1_out), .wire_lvl(pin1_in));
    ccpu_pin_src pin2_src (.core_clk, .drv_oe(pin2_oe), .drv_val(pin2_out), .wire_lvl(pin2_in));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // counts conversion starts seen at the edge
    always @(posedge core_clk) if (adc_start === 1'b1) n_adc <= n_adc + 16'h1;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] rq);
        address    <= a;
        writedata  <= {24'h0, d};
        byteenable <= be;
        write      <= wr;
        read       <= !wr;
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rq = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] rq;
        bus(1'b1, a, d, 4'hf, rq);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] rq;
        bus(1'b0, a, 8'h00, 4'hf, rq);
        check(what, {8'h0, exp}, {8'h0, rq});
    endtask : rd_chk

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // watchdog at about twenty times the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        adc_enabled = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        // reset values, refused accesses, unimplemented bits
        rd_chk("ctl1 reset", `CCPU_IDX_CTL1, `CCPU_CTL_RESET);
        rd_chk("period reset", `CCPU_IDX_PERIOD, `CCPU_PERIOD_RESET);
        rd_chk("unmapped", 4'hf, 8'h00);
        bus(1'b1, `CCPU_IDX_CTL1, 8'h05, 4'h0, q);
        rd_chk("ctl1 no enable", `CCPU_IDX_CTL1, 8'h00);
        wr(`CCPU_IDX_CTL1, 8'hff);
        rd_chk("ctl1 top bits", `CCPU_IDX_CTL1, 8'h3f);
        // every capture mode; off first so the prescaler starts from zero
        for (int i = 0; i < 4; i++) begin
            tv = 16'(16'h1234 + 16'h1111 * i);
            wr(`CCPU_IDX_CTL1, 8'h00);
            wr(`CCPU_IDX_T1_LOW, tv[7:0]);
            wr(`CCPU_IDX_T1_HIGH, tv[15:8]);
            wr(`CCPU_IDX_CTL1, {4'h0, cap_mode[i]});
            wr(`CCPU_IDX_STATUS, 8'h01);
            pin1_src.pulses(cap_cnt[i] - 1, 3);
            rd_chk("flag early", `CCPU_IDX_STATUS, 8'h00);
            pin1_src.pulses(1, 3);
            repeat (4) @(posedge core_clk);
            rd_chk("flag set", `CCPU_IDX_STATUS, 8'h01);
            rd_chk("cap low", `CCPU_IDX_CC1_LOW, tv[7:0]);
            rd_chk("cap high", `CCPU_IDX_CC1_HIGH, tv[15:8]);
        end
        // unread value overwritten by a capture from a port write
        wr(`CCPU_IDX_CTL1, 8'h05);
        wr(`CCPU_IDX_T1_HIGH, 8'h5a);
        pin1_src.pulses(1, 3);
        wr(`CCPU_IDX_T1_HIGH, 8'ha5);
        wr(`CCPU_IDX_PORT, 8'h02);
        wr(`CCPU_IDX_PORT, 8'h03);
        repeat (4) @(posedge core_clk);
        rd_chk("overwrite", `CCPU_IDX_CC1_HIGH, 8'ha5);
        wr(`CCPU_IDX_PORT, 8'h02);
        // compare rows; 0xff40 start keeps clear of overflow
        wr(`CCPU_IDX_CC1_LOW, 8'h50);
        wr(`CCPU_IDX_CC1_HIGH, 8'hff);
        wr(`CCPU_IDX_CC2_LOW, 8'h50);
        wr(`CCPU_IDX_CC2_HIGH, 8'hff);
        for (int i = 0; i < 6; i++) begin
            wr(`CCPU_IDX_TIMER_CTL, 8'h00);
            wr(`CCPU_IDX_T1_LOW, 8'h40);
            wr(`CCPU_IDX_T1_HIGH, 8'hff);
            wr(r_ctl[i], {4'h0, r_md[i]});
            adc_enabled <= r_adc[i];
            wr(`CCPU_IDX_STATUS, 8'h07);
            adc_base = n_adc;
            wr(`CCPU_IDX_TIMER_CTL, 8'h01);
            repeat (40) @(posedge core_clk);
            wr(`CCPU_IDX_TIMER_CTL, 8'h00);
            rd_chk("cmp flags", `CCPU_IDX_STATUS, r_st[i]);
            rd_chk("t1 high", `CCPU_IDX_T1_HIGH, r_t1h[i]);
            if (i < 3) check("cmp pin", {15'h0, r_pin[i]}, {15'h0, pin1_out});
            check("adc starts", r_n[i], 16'(n_adc - adc_base));
        end
        wr(`CCPU_IDX_CTL1, 8'h08);
        check("pin before clear", 16'h1, {15'h0, pin1_out});
        wr(`CCPU_IDX_CTL2, 8'h00);
        wr(`CCPU_IDX_CTL1, 8'h00);
        // back to a compare mode so the pin shows the unit latch again
        wr(`CCPU_IDX_CTL1, 8'h0a);
        check("cleared pin", 16'h0, {15'h0, pin1_out});
        // both units in pwm, period 16 clocks, duties 6 and 8 clocks
        wr(`CCPU_IDX_PERIOD, 8'h03);
        wr(`CCPU_IDX_CC1_LOW, 8'h01);
        wr(`CCPU_IDX_CC2_LOW, 8'h02);
        wr(`CCPU_IDX_PORT, 8'h0a);
        wr(`CCPU_IDX_CTL1, 8'h2c);
        wr(`CCPU_IDX_CTL2, 8'h0f);
        wr(`CCPU_IDX_TIMER_CTL, 8'h02);
        repeat (48) @(posedge core_clk);
        h1 = 16'h0;
        h2 = 16'h0;
        // four whole periods, so the phase of the window does not matter
        repeat (64) begin
            @(negedge core_clk);
            h1 = h1 + 16'(pin1_out);
            h2 = h2 + 16'(pin2_out);
        end
        check("pwm1 high", 16'd24, h1);
        check("pwm2 high", 16'd32, h2);
        rd_chk("duty latched", `CCPU_IDX_CC1_HIGH, 8'h01);
        wrap_up();
    end
endmodule : ccpu_top_tb
